// ===== verilog/ubg_pkg.sv
// Constants, types and register layout of the serial baud and FIFO block
package ubg_pkg;
   localparam longint CLK_HZ      = 100_000_000; // System clock rate
   localparam longint PRE_NORM_HZ = 1_843_200;   // Normal prescale rate
   localparam longint PRE_FAST_HZ = 7_372_800;   // High-speed prescale rate
   localparam int     ACC_W       = 24;          // Phase accumulator width
   localparam longint ACC_ONE     = longint'(1) << ACC_W;
   // Fractional increments, so no integer divider ratio is needed
   localparam logic [ACC_W-1:0] INC_NORM = ACC_W'((PRE_NORM_HZ * ACC_ONE) / CLK_HZ);
   localparam logic [ACC_W-1:0] INC_FAST = ACC_W'((PRE_FAST_HZ * ACC_ONE) / CLK_HZ);

   localparam int         ADDR_W   = 6;     // Byte address width
   localparam logic [3:0] IDX_DATA = 4'h0;  // Receive/transmit data or low latch
   localparam logic [3:0] IDX_IER  = 4'h1;  // Interrupt enable or high latch
   localparam logic [3:0] IDX_IIR  = 4'h2;  // Ident (read), FIFO control (write)
   localparam logic [3:0] IDX_LCR  = 4'h3;  // Line control
   localparam logic [3:0] IDX_LSR  = 4'h5;  // Line status
   localparam logic [3:0] IDX_HS   = 4'h8;  // High-speed configuration
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam int          PTR_W      = 4;     // FIFO pointer width
   localparam int          CNT_W      = 5;     // FIFO fill width
   localparam logic [4:0]  FIFO_DEPTH = 5'h10; // Sixteen entries
   localparam logic [4:0]  ONE_DEEP   = 5'h01; // Holding-register mode
   localparam logic [4:0]  TRIG_L0    = 5'h01;
   localparam logic [4:0]  TRIG_L1    = 5'h04;
   localparam logic [4:0]  TRIG_L2    = 5'h08;
   localparam logic [4:0]  TRIG_L3    = 5'h0E;
   localparam logic [15:0] DIV_ZERO_RELOAD = 16'h0002; // Zero acts as three
   localparam int          HS_DIV_BIT = 15;    // Divisor bit that picks fast path
   localparam logic [3:0]  DATA_BITS_MIN = 4'h5;
   localparam logic [9:0]  TICKS_PER_BIT = 10'h010;
   localparam logic [9:0]  TMO_CHARS     = 10'h004;
   localparam logic [1:0]  IIR_FIFO_ON   = 2'h3;

   localparam int LSR_DR = 0, LSR_OE = 1, LSR_PE = 2, LSR_FE = 3;
   localparam int LSR_BI = 4, LSR_TX_HOLDING_EMPTY = 5, LSR_TEMT = 6, LSR_ERR = 7;

   typedef enum logic [3:0] {
      IID_NONE = 4'h1, IID_TX_HOLDING_EMPTY = 4'h2, IID_RDA = 4'h4, IID_LSR = 4'h6, IID_TMO = 4'hC
   } ubg_iid_t;

   typedef struct packed {
      logic       divisor_latch_access_bit;
      logic       set_break;
      logic       stick_parity;
      logic       even_parity;
      logic       parity_en;
      logic       two_stop;
      logic [1:0] word_len;
   } ubg_lcr_t;

   typedef struct packed {
      logic [3:0] zero;
      logic       modem_en;
      logic       line_en;
      logic       tx_holding_empty_en;
      logic       rda_en;
   } ubg_ier_t;

   typedef struct packed {
      logic [1:0] trig;
      logic [1:0] rsv;
      logic       dma_mode;
      logic       tx_reset;
      logic       rx_reset;
      logic       fifo_enable_bit;
   } ubg_fcr_t;

   typedef struct packed {
      logic       bi;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } ubg_rxchar_t;
endpackage

// ===== verilog/ubg_uart_core.sv
// Baud generator, FIFOs, interrupt ident and line status behind AXI4-Lite
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
module ubg_uart_core
   import ubg_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              rx_valid,
   input  wire ubg_rxchar_t       rx_char,
   output logic                   tx_valid,
   output logic [7:0]             tx_data,
   input  wire logic              tx_ready,
   input  wire logic              tx_shift_idle,
   output logic                   baud_clk,
   output logic                   baud_tick,
   output logic                   int_req
);
   // Index decode shared by read and write paths
   function automatic logic idx_ok(input logic [3:0] i);
      return i == IDX_DATA || i == IDX_IER || i == IDX_IIR || i == IDX_LCR
          || i == IDX_LSR || i == IDX_HS;
   endfunction
   // Counter reload for a divisor
   function automatic logic [15:0] div_reload(input logic [15:0] d);
      return (d == 16'h0000) ? DIV_ZERO_RELOAD : d - 16'h0001;
   endfunction
   // Start, data, parity and stop bits of one character
   function automatic logic [9:0] char_bits(input ubg_lcr_t l);
      return 10'(DATA_BITS_MIN + {2'b00, l.word_len} + 4'h2 + {3'b000, l.parity_en}
             + {3'b000, l.two_stop});
   endfunction

   logic [7:0]          dll, baud_divisor_high;        // Divisor latches
   ubg_ier_t            interrupt_enable_reg;             // Interrupt enables
   ubg_lcr_t            lcr;             // Line control
   ubg_fcr_t            fifo_control_reg;             // FIFO control copy
   logic                hs;              // High-speed prescale select
   logic                aw_hold, w_hold; // Captured write halves
   logic [3:0]          aw_idx;          // Captured write index
   logic [7:0]          w_byte;          // Captured write byte
   logic                w_lane;          // Low byte lane enabled
   logic                wr_go, wr_en, rd_go;
   logic [3:0]          rd_idx;
   logic                div_wr, div_wr_q;
   logic                thr_wr, fcr_wr, fen_chg, rbr_rd, lsr_rd, iir_rd;
   logic [ACC_W-1:0]    acc;             // Prescale phase
   logic [ACC_W:0]      acc_sum;
   logic                pre_tick, fast;
   logic [15:0]         eff, reload, cnt, next_cnt;
   ubg_rxchar_t         rx_mem [16];     // Receive characters with flags
   logic [15:0]         rx_errv;         // Slot holds a flagged character
   logic [PTR_W-1:0]    rx_wp, rx_rp;
   logic [CNT_W-1:0]    rx_cnt, cap, trig;
   logic                rx_push, rx_pop, rx_flush, top_load, top_q;
   logic                oe, pe, fe, bi;  // Sticky line errors
   logic [7:0]          tx_mem [16];
   logic [PTR_W-1:0]    tx_wp, tx_rp;
   logic [CNT_W-1:0]    tx_cnt;
   logic                tx_push, tx_pop, tx_flush;
   logic                two_seen, tx_holding_empty_ind, tx_holding_empty_q, tx_holding_empty_pend;
   logic [9:0]          dly_cnt, tmo_cnt, tmo_lim;
   logic                tmo_pend, tmo_run;
   logic                rls_act, rda_act;
   ubg_iid_t            iid;
   logic [7:0]          iir_val, lsr_val;

   // Write channel: halves taken in either order, answered after both
   assign awready = !aw_hold && !bvalid;
   assign wready  = !w_hold && !bvalid;
   assign wr_go   = aw_hold && w_hold && !bvalid;
   assign wr_en   = wr_go && w_lane && idx_ok(aw_idx);
   assign arready = !rvalid;
   assign rd_go   = arvalid && arready;
   assign rd_idx  = araddr[5:2];

   // Capture of address and data halves
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold  <= 1'b0;
         aw_idx  <= 4'h0;
         w_byte  <= 8'h00;
         w_lane  <= 1'b0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_hold <= 1'b1;
            aw_idx  <= awaddr[5:2];
         end
         else if (wr_go)
            aw_hold <= 1'b0;
         if (wvalid && wready)
         begin
            w_hold <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
         end
         else if (wr_go)
            w_hold <= 1'b0;
      end
   end

   // Write response; unmapped index answers with an error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid <= 1'b1;
         bresp  <= idx_ok(aw_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'b0;
   end

   // Access strobes; data offsets reach latches only with access bit set
   assign div_wr  = wr_en && lcr.divisor_latch_access_bit
                 && (aw_idx == IDX_DATA || aw_idx == IDX_IER);
   assign thr_wr  = wr_en && !lcr.divisor_latch_access_bit && aw_idx == IDX_DATA;
   assign fcr_wr  = wr_en && aw_idx == IDX_IIR;
   assign fen_chg = fcr_wr && (w_byte[0] != fifo_control_reg.fifo_enable_bit);
   assign rbr_rd  = rd_go && !lcr.divisor_latch_access_bit && rd_idx == IDX_DATA;
   assign lsr_rd  = rd_go && rd_idx == IDX_LSR;
   assign iir_rd  = rd_go && rd_idx == IDX_IIR;

   // Control registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dll <= 8'h00;
         baud_divisor_high <= 8'h00;
         interrupt_enable_reg <= '0;
         lcr <= '0;
         fifo_control_reg <= '0;
         hs  <= 1'b0;
      end
      else if (wr_en)
      begin
         if (div_wr && aw_idx == IDX_DATA)
            dll <= w_byte;
         if (div_wr && aw_idx == IDX_IER)
            baud_divisor_high <= w_byte;
         if (!lcr.divisor_latch_access_bit && aw_idx == IDX_IER)
            interrupt_enable_reg <= {4'h0, w_byte[3:0]};
         if (aw_idx == IDX_LCR)
            lcr <= w_byte;
         if (fcr_wr)
            fifo_control_reg <= {w_byte[7:6], 2'b00, w_byte[3], 2'b00, w_byte[0]};
         if (aw_idx == IDX_HS)
            hs <= w_byte[0];
      end
   end

   // Prescale by phase accumulation; fast only with high-speed bit
   assign fast     = hs && baud_divisor_high[HS_DIV_BIT-8];
   assign eff      = fast ? {1'b0, baud_divisor_high[6:0], dll} : {baud_divisor_high, dll};
   assign reload   = div_reload(eff);
   assign acc_sum  = {1'b0, acc} + {1'b0, fast ? INC_FAST : INC_NORM};
   assign pre_tick = acc_sum[ACC_W];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         acc <= '0;
      else
         acc <= acc_sum[ACC_W-1:0];
   end

   // Divisor counter, reloaded straight after a latch write
   always_comb
   begin
      if (div_wr_q)
         next_cnt = reload;
      else if (pre_tick)
         next_cnt = (cnt == 16'h0000) ? reload : cnt - 16'h0001;
      else
         next_cnt = cnt;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt       <= 16'h0000;
         div_wr_q  <= 1'b0;
         baud_tick <= 1'b0;
         baud_clk  <= 1'b0;
      end
      else
      begin
         div_wr_q  <= div_wr;
         cnt       <= next_cnt;
         baud_tick <= pre_tick && cnt == 16'h0000 && !div_wr_q;
         if (eff == 16'h0001)
            baud_clk <= ~acc_sum[ACC_W-1];
         else if (eff == 16'h0002)
            baud_clk <= baud_clk ^ pre_tick;
         else
            baud_clk <= !(next_cnt >= reload - 16'h0001);
      end
   end

   // Receive FIFO; one deep when FIFOs are off
   assign cap      = fifo_control_reg.fifo_enable_bit ? FIFO_DEPTH : ONE_DEEP;
   assign rx_flush = fen_chg || (fcr_wr && w_byte[1]);
   assign rx_push  = rx_valid && rx_cnt < cap && !rx_flush;
   assign rx_pop   = rbr_rd && rx_cnt != '0 && !rx_flush;
   assign top_load = (rx_push && (rx_cnt == '0 || (rx_pop && rx_cnt == ONE_DEEP)))
                  || (rx_pop && rx_cnt > ONE_DEEP);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || rx_flush)
      begin
         rx_wp   <= '0;
         rx_rp   <= '0;
         rx_cnt  <= '0;
         rx_errv <= 16'h0000;
      end
      else
      begin
         if (rx_push)
         begin
            rx_mem[rx_wp]  <= rx_char;
            rx_errv[rx_wp] <= rx_char.pe || rx_char.fe || rx_char.bi;
            rx_wp          <= rx_wp + 1'b1;
         end
         if (rx_pop)
         begin
            rx_rp <= rx_rp + 1'b1;
            if (!(rx_push && rx_wp == rx_rp))
               rx_errv[rx_rp] <= 1'b0;
         end
         rx_cnt <= rx_cnt + CNT_W'(rx_push) - CNT_W'(rx_pop);
      end
   end

   // Sticky errors; top-of-FIFO flags load a cycle after the top changes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {oe, pe, fe, bi} <= 4'h0;
      end
      else
      begin
         oe <= (rx_valid && rx_cnt >= cap) || (oe && !lsr_rd);
         pe <= (top_q && rx_mem[rx_rp].pe) || (pe && !lsr_rd);
         fe <= (top_q && rx_mem[rx_rp].fe) || (fe && !lsr_rd);
         bi <= (top_q && rx_mem[rx_rp].bi) || (bi && !lsr_rd);
      end
   end

   // Head change delayed a cycle, so flags follow the new top entry
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         top_q <= 1'b0;
      else
         top_q <= top_load;
   end

   // Receive idle timer in 16x ticks, four character times
   assign tmo_lim = TMO_CHARS * TICKS_PER_BIT * char_bits(lcr);
   assign tmo_run = fifo_control_reg.fifo_enable_bit && interrupt_enable_reg.rda_en && rx_cnt != '0;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tmo_cnt  <= 10'h000;
         tmo_pend <= 1'b0;
      end
      else if (rx_pop || !tmo_run)
      begin
         tmo_cnt  <= 10'h000;
         tmo_pend <= 1'b0;
      end
      else if (rx_push && !tmo_pend)
         tmo_cnt <= 10'h000;
      else if (baud_tick && !tmo_pend)
      begin
         tmo_cnt  <= tmo_cnt + 10'h001;
         tmo_pend <= tmo_cnt + 10'h001 >= tmo_lim;
      end
   end

   // Transmit FIFO
   assign tx_flush = fen_chg || (fcr_wr && w_byte[2]);
   assign tx_push  = thr_wr && tx_cnt < cap && !tx_flush;
   assign tx_valid = tx_cnt != '0;
   assign tx_data  = tx_mem[tx_rp];
   assign tx_pop   = tx_valid && tx_ready && !tx_flush;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || tx_flush)
      begin
         tx_wp  <= '0;
         tx_rp  <= '0;
         tx_cnt <= '0;
      end
      else
      begin
         if (tx_push)
         begin
            tx_mem[tx_wp] <= w_byte;
            tx_wp         <= tx_wp + 1'b1;
         end
         if (tx_pop)
            tx_rp <= tx_rp + 1'b1;
         tx_cnt <= tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);
      end
   end

   // Empty flag held back after a lone byte drains in FIFO mode
   assign tx_holding_empty_ind = tx_cnt == '0 && dly_cnt == 10'h000;
   always_ff @(posedge aclk)
   begin
      if (!aresetn || tx_flush)
      begin
         dly_cnt  <= 10'h000;
         two_seen <= 1'b0;
      end
      else
      begin
         if (tx_cnt >= 5'h02)
            two_seen <= 1'b1;
         else if (tx_holding_empty_ind)
            two_seen <= 1'b0;
         if (tx_pop && tx_cnt == ONE_DEEP && !tx_push && !two_seen && fifo_control_reg.fifo_enable_bit)
            dly_cnt <= (char_bits(lcr) - 10'h001) * TICKS_PER_BIT;
         else if (baud_tick && dly_cnt != 10'h000)
            dly_cnt <= dly_cnt - 10'h001;
      end
   end

   // Transmit-empty pending; a set in the clearing cycle wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tx_holding_empty_q    <= 1'b1;
         tx_holding_empty_pend <= 1'b0;
      end
      else
      begin
         tx_holding_empty_q <= tx_holding_empty_ind;
         if ((tx_holding_empty_ind && !tx_holding_empty_q) || fen_chg)
            tx_holding_empty_pend <= 1'b1;
         else if (thr_wr || (iir_rd && iid == IID_TX_HOLDING_EMPTY))
            tx_holding_empty_pend <= 1'b0;
      end
   end

   // Interrupt identification by priority
   assign trig    = fifo_control_reg.trig == 2'h0 ? TRIG_L0 : fifo_control_reg.trig == 2'h1 ? TRIG_L1
                  : fifo_control_reg.trig == 2'h2 ? TRIG_L2 : TRIG_L3;
   assign rls_act = interrupt_enable_reg.line_en && (oe || pe || fe || bi);
   assign rda_act = interrupt_enable_reg.rda_en && (fifo_control_reg.fifo_enable_bit ? rx_cnt >= trig : rx_cnt != '0);
   always_comb
   begin
      if (rls_act)
         iid = IID_LSR;
      else if (rda_act)
         iid = IID_RDA;
      else if (interrupt_enable_reg.rda_en && tmo_pend)
         iid = IID_TMO;
      else if (interrupt_enable_reg.tx_holding_empty_en && tx_holding_empty_pend)
         iid = IID_TX_HOLDING_EMPTY;
      else
         iid = IID_NONE;
   end
   assign iir_val = {fifo_control_reg.fifo_enable_bit ? IIR_FIFO_ON : 2'h0, 2'h0, iid};
   assign lsr_val = {fifo_control_reg.fifo_enable_bit && rx_errv != 16'h0000, tx_holding_empty_ind && tx_shift_idle,
                     tx_holding_empty_ind, bi, fe, pe, oe, rx_cnt != '0};

   // Read answer and interrupt line
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
         int_req <= 1'b0;
      end
      else
      begin
         int_req <= iid != IID_NONE;
         if (rd_go)
         begin
            rvalid <= 1'b1;
            rresp  <= idx_ok(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            case (rd_idx)
               IDX_DATA: rdata <= {24'h0, lcr.divisor_latch_access_bit ? dll
                                           : rx_mem[rx_rp].data};
               IDX_IER:  rdata <= {24'h0, lcr.divisor_latch_access_bit ? baud_divisor_high : interrupt_enable_reg};
               IDX_IIR:  rdata <= {24'h0, iir_val};
               IDX_LCR:  rdata <= {24'h0, lcr};
               IDX_LSR:  rdata <= {24'h0, lsr_val};
               IDX_HS:   rdata <= {31'h0, hs};
               default:  rdata <= 32'h0000_0000;
            endcase
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   a_div_reload: assert property (@(posedge aclk) disable iff (!aresetn)
      div_wr |-> ##2 cnt == reload) else $error("counter not reloaded");
   a_div_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      eff == 16'h0000 |-> reload == DIV_ZERO_RELOAD) else $error("zero not three");
   a_div_two: assert property (@(posedge aclk) disable iff (!aresetn)
      eff == 16'h0002 && pre_tick && $stable(eff) |=> baud_clk != $past(baud_clk))
      else $error("half rate not toggling");
   a_low_two: assert property (@(posedge aclk) disable iff (!aresetn)
      eff >= 16'h0003 && !div_wr_q && pre_tick && cnt == 16'h0000 |=> !baud_clk)
      else $error("period not low first");
   a_rda_trig: assert property (@(posedge aclk) disable iff (!aresetn)
      interrupt_enable_reg.rda_en && fifo_control_reg.fifo_enable_bit && rx_cnt >= trig && !rls_act |-> iid == IID_RDA)
      else $error("trigger not reported");
   a_lsr_prio: assert property (@(posedge aclk) disable iff (!aresetn)
      rls_act |-> iir_val[3:0] == 4'h6) else $error("line status not first");
   a_dr_set: assert property (@(posedge aclk) disable iff (!aresetn)
      rx_push |=> lsr_val[LSR_DR]) else $error("data ready missing");
   a_tmo_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      tmo_pend && rx_pop |=> !tmo_pend && tmo_cnt == 10'h000)
      else $error("timeout not cleared");
   a_tx_holding_empty_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      thr_wr && !fen_chg && !(tx_holding_empty_ind && !tx_holding_empty_q) |=> !tx_holding_empty_pend)
      else $error("empty irq not cleared");
   a_iir_reset: assert property (@(posedge aclk)
      !aresetn |=> iir_val == 8'h01) else $error("ident not 01 after reset");
endmodule

// ===== tb/ubg_far_end.sv
// Far serial end: offers received characters and drains transmitted bytes
module ubg_far_end
   import ubg_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        send,
   input  wire ubg_rxchar_t send_char,
   output ubg_rxchar_t      rx_char,
   output logic             rx_valid,
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   output logic             tx_ready,
   output logic             tx_shift_idle,
   output logic [7:0]       last_tx
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] busy; // Shift time left for a taken byte
   // Quiet start: idle line, empty shifter
   initial
   begin
      rx_valid = 1'b0;
      rx_char = '0;
      tx_ready = 1'b0;
      tx_shift_idle = 1'b1;
      busy = 4'h0;
      last_tx = 8'h00;
   end
   // One character per request; idle data flips so stale bits never match
   always @(posedge aclk)
   begin
      rx_valid <= send;
      rx_char  <= send ? send_char : ~rx_char;
   end
   // Take a byte, then stay busy as a real shifter would before asking again
   always @(posedge aclk)
   begin
      if (tx_valid && tx_ready)
      begin
         last_tx  <= tx_data;
         tx_ready <= 1'b0;
         busy     <= 4'hF;
      end
      else if (busy != 4'h0)
         busy <= busy - 4'h1;
      else
         tx_ready <= 1'b1;
      tx_shift_idle <= (busy == 4'h0) && !(tx_valid && tx_ready);
   end
endmodule

// ===== tb/uart_baud_gen_fifo_irq_tb_top.sv
// Register-level testbench of the baud, FIFO and interrupt block
module uart_baud_gen_fifo_irq_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ubg_pkg::*;
   logic              aclk = 1'b0, aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic              awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, send = 1'b0;
   logic              bready = 1'b1, rready = 1'b1; // Always ready for answers
   logic [31:0]       wdata = '0, rdata;
   logic [3:0]        wstrb = 4'hF;
   ubg_rxchar_t       send_char = '0, rx_char;
   logic [1:0]        bresp, rresp, last_resp;
   logic              awready, wready, bvalid, arready, rvalid, rx_valid, tx_valid;
   logic              tx_ready, tx_shift_idle, baud_clk, baud_tick, int_req;
   logic [7:0]        tx_data, last_tx;
   int                fails = 0, tests_run = 0, n, i, ticks, rises;
   logic              clk_was = 1'b0; // Generator output at the previous edge
   // Divisor table: high latch, low latch (high bit 7 also picks fast path)
   logic [7:0]        div_hi [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80};
   logic [7:0]        div_lo [5] = '{8'h02, 8'h01, 8'h00, 8'h02, 8'h01};
   int                ticks_exp [5] = '{10, 20, 7, 40, 80}; // Ticks per 1085 cycles
   always #5 aclk = ~aclk;
   ubg_uart_core i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .rx_valid, .rx_char, .tx_valid, .tx_data, .tx_ready,
      .tx_shift_idle, .baud_clk, .baud_tick, .int_req);
   ubg_far_end i_far (.aclk, .send, .send_char, .rx_char, .rx_valid, .tx_valid,
      .tx_data, .tx_ready, .tx_shift_idle, .last_tx);
   // Verdict and end of run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // A wait ran out: count it and stop
   task automatic expire;
      fails++;
      complete_run();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, seen);
         fails++;
      end
   endtask
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 50) expire();
      last_resp = bresp;
   endtask
   // Read and compare; response code kept for the caller
   task automatic rd(input logic [5:0] a, input logic [31:0] exp, input string what);
      araddr  <= a;
      arvalid <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 50) expire();
      last_resp = rresp;
      chk(rdata, exp, what);
   endtask
   // Far end delivers one character
   task automatic push(input ubg_rxchar_t c);
      send      <= 1'b1;
      send_char <= c;
      @(posedge aclk);
      send <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   // Tick count over a fixed window; one tick of slack for phase
   task automatic count_ticks(input int exp);
      ticks = 0;
      rises = 0;
      repeat (8) @(posedge aclk);
      clk_was = baud_clk;
      repeat (1085)
      begin
         @(posedge aclk);
         if (baud_tick === 1'b1) ticks++;
         if (baud_clk === 1'b1 && clk_was === 1'b0) rises++;
         clk_was = baud_clk;
      end
      chk(32'(ticks >= exp - 1 && ticks <= exp + 1), 32'h1, "tick count");
      chk(32'(rises >= exp - 1 && rises <= exp + 1), 32'h1, "clock rises");
   endtask
   task automatic wait_irq(input int limit);
      for (n = 0; n < limit; n++)
      begin
         @(posedge aclk);
         if (int_req === 1'b1) break;
      end
      if (n == limit) expire();
   endtask
   // Main sequence
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(6'h08, 32'h01, "iir");
      rd(6'h14, 32'h60, "lsr");
      rd(6'h18, 32'h00, "unmapped");
      chk({30'h0, last_resp}, {30'h0, RESP_SLVERR}, "rresp");
      wr(6'h18, 8'h00);
      chk({30'h0, last_resp}, {30'h0, RESP_SLVERR}, "bresp");
      $display("test reset done");
      wr(6'h0C, 8'h80);
      chk({30'h0, last_resp}, {30'h0, RESP_OKAY}, "bresp ok");
      wr(6'h04, 8'hFF);
      wr(6'h00, 8'hFF);
      rd(6'h00, 32'hFF, "low latch");
      rd(6'h04, 32'hFF, "high latch");
      for (i = 0; i < 5; i++)
      begin
         wr(6'h20, {7'h0, div_hi[i][7]});
         wr(6'h04, div_hi[i]);
         wr(6'h00, div_lo[i]);
         count_ticks(ticks_exp[i]);
      end
      wr(6'h20, 8'h00);
      wr(6'h04, 8'h00);
      wr(6'h00, 8'h01);
      wr(6'h0C, 8'h03);
      $display("test divisor done");
      wr(6'h08, 8'h01);
      wr(6'h04, 8'h01);
      push({3'h0, 8'h5A});
      rd(6'h08, 32'hC4, "iir");
      rd(6'h14, 32'h61, "lsr");
      rd(6'h00, 32'h5A, "rx data");
      rd(6'h08, 32'hC1, "iir");
      rd(6'h14, 32'h60, "lsr");
      wr(6'h04, 8'h05);
      push({3'h1, 8'h33});
      rd(6'h08, 32'hC6, "iir");
      rd(6'h14, 32'hE5, "lsr");
      rd(6'h08, 32'hC4, "iir");
      rd(6'h00, 32'h33, "rx data");
      $display("test receive done");
      wr(6'h08, 8'h41);
      wr(6'h04, 8'h01);
      push({3'h0, 8'h11});
      wait_irq(40000);
      chk(32'(n > 30000), 32'h1, "timeout delay");
      rd(6'h08, 32'hCC, "iir");
      rd(6'h00, 32'h11, "rx data");
      rd(6'h08, 32'hC1, "iir");
      $display("test timeout done");
      wr(6'h04, 8'h02);
      rd(6'h08, 32'hC2, "iir");
      rd(6'h08, 32'hC1, "iir");
      wr(6'h00, 8'hA5);
      wait_irq(10000);
      chk(32'(n > 7000), 32'h1, "empty delay");
      chk({24'h0, last_tx}, 32'hA5, "tx data");
      rd(6'h08, 32'hC2, "iir");
      wr(6'h00, 8'h5C);
      rd(6'h08, 32'hC1, "iir");
      $display("test transmit done");
      wr(6'h04, 8'h00);
      push({3'h2, 8'h77});
      repeat (20) @(posedge aclk);
      rd(6'h08, 32'hC1, "iir");
      rd(6'h14, 32'h89, "lsr");
      repeat (8000) @(posedge aclk);
      rd(6'h14, 32'hE1, "lsr");
      $display("test polled done");
      complete_run();
   end
endmodule
